// file: design/dll_ctrl_regs.vh
// Constants for the delay locked loop control block
// Overview of operation
// - Step delay code so feedback meets reference
// - Broadcast delay code to both slave lines
// - Hold input freezes the delay code
// - Latch input captures bus code, keeps it
// - Each output picks its own delay tap
// - Secondary adds 45, 22.5, 11.25 degree shift
// - Secondary optionally divided by two or four
// - Duty correction enabled per output separately
// - Lock output asserted when loop is locked
// - Time reference or clock injection removal mode
// - Delay code is seven bits, six to zero
`ifndef DLL_CTRL_REGS_VH
`define DLL_CTRL_REGS_VH
// APB register byte addresses
`define ADDR_CTRL       12'h000
`define ADDR_TAPS       12'h004
`define ADDR_STATUS     12'h008
`define ADDR_LATCHED    12'h00c
// Control register fields
`define CTRL_MODE_BIT   0
`define CTRL_DCC_P_BIT  1
`define CTRL_DCC_S_BIT  2
`define CTRL_DIV_LSB    3
`define CTRL_FINE_LSB   5
`define CTRL_RESET_VAL  32'h0000_0000
// Divider selections
`define DIV_NONE        2'h0
`define DIV_BY2         2'h1
`define DIV_BY4         2'h2
// Fine shift selections: none, 45, 22.5, 11.25 degrees
`define FINE_NONE       2'h0
`define FINE_45         2'h1
`define FINE_22P5       2'h2
`define FINE_11P25      2'h3
// Delay code
`define CODE_W          7
`define CODE_RESET      7'h40
// Lock criteria: coinciding edges counted before the next one locks, lone reference edges counted before the next one unlocks
`define LOCK_COUNT      4'h8
`define UNLOCK_COUNT    4'h4
`endif

// file: design/dll_ctrl.v
// Digital control of a delay locked loop with APB configuration
//
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`include "dll_ctrl_regs.vh"
module dll_ctrl #(
  parameter TAPS = 128
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        ref_clk_in,
  input  wire        fb_clk_in,
  input  wire        code_hold,
  input  wire        code_update_latch,
  output reg  [6:0]  delay_code_bus,
  output reg  [6:0]  latched_code,
  output reg  [6:0]  primary_tap,
  output reg  [6:0]  secondary_tap,
  output reg  [1:0]  secondary_fine,
  output reg         primary_clock_out,
  output reg         secondary_clock_out,
  output reg         primary_dcc_en,
  output reg         secondary_dcc_en,
  output reg         injection_removal_mode,
  output reg         lock
);

  ////////////////////////////////////////////////////////////////////////
  // Register map, one aligned word each
  //   0x000 control, read/write
  //     [0]     injection removal mode, else time reference delay
  //     [1]     duty correction on the primary output
  //     [2]     duty correction on the secondary output
  //     [4:3]   secondary divider: 0 none, 1 by two, 2 by four
  //     [6:5]   fine shift: 0 none, 1 45, 2 22.5, 3 11.25 degrees
  //     [31:7]  reserved, write ignored, read zero
  //   0x004 tap selects, read/write
  //     [6:0]   primary output tap
  //     [13:7]  secondary output tap
  //     [31:14] reserved
  //   0x008 status, read only
  //     [6:0]   present delay code
  //     [7]     lock flag
  //   0x00c latched code, read only
  //     [6:0]   code captured at the last latch request
  // Any other address answers with an error and reads zero.
  //
  // Bus timing
  //   Ready rises in the access phase, so every transfer has
  //   no wait state; a write lands at the access edge.
  //   Read data are registered during setup, so the address
  //   must not change between setup and access.
  //
  // Loop behaviour
  //   Reference and feedback are levels sampled on the bus
  //   clock; only their rising edges matter.
  //   A reference edge with feedback still low steps the code
  //   down, a feedback edge with reference low steps it up,
  //   one step per edge, saturating at both ends.
  //   Hold freezes the code; the detector keeps running, so
  //   lock can still change while the code is held.
  //   Lock needs nine coinciding edges in a row and drops
  //   after five reference edges without feedback.
  //   Tap requests beyond the chain length are clamped.
  // Limitation: phase is only resolved to one bus clock, so
  //   reference and feedback must run far slower than it.

  ////////////////////////////////////////////////////////////////////////
  // Registers
  reg  [31:0] ctrl_reg;
  reg  [13:0] taps_reg;
  reg  [6:0]  code_reg;
  reg  [6:0]  latch_reg;
  reg         ref_d_reg;
  reg         fb_d_reg;
  reg  [3:0]  match_reg;
  reg  [3:0]  miss_reg;
  reg         lock_reg;
  reg  [1:0]  div_reg;
  reg         sec_src_reg;
  reg  [6:0]  code_next;
  reg  [3:0]  match_next;
  reg  [3:0]  miss_next;
  reg         lock_next;

  wire        wr_en;
  wire        rd_en;
  wire        ref_rise;
  wire        fb_rise;
  wire        fb_late;
  wire        fb_early;
  wire [1:0]  div_sel;
  reg  [31:0] rd_data;

  // Last usable tap, kept wide and cut on purpose below
  localparam [31:0] TAP_LAST = TAPS - 1;

  // Clamp a tap request to the chain length
  function [6:0] clamp_tap;
    input [6:0] tap;
    begin
      if (tap > TAP_LAST)
        clamp_tap = TAP_LAST[6:0];
      else
        clamp_tap = tap;
    end
  endfunction

  // Decoded register addresses; others are refused
  function addr_mapped;
    input [11:0] addr;
    begin
      addr_mapped = (addr == `ADDR_CTRL) || (addr == `ADDR_TAPS) ||
                    (addr == `ADDR_STATUS) || (addr == `ADDR_LATCHED);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // APB decode: zero wait states, so access completes in one cycle
  assign wr_en   = psel & penable & pwrite;
  assign rd_en   = psel & ~pwrite;
  assign div_sel = ctrl_reg[`CTRL_DIV_LSB+1:`CTRL_DIV_LSB];

  // Read mux; unmapped addresses read zero
  always @* begin
    rd_data = 32'h0000_0000;
    case (paddr)
      `ADDR_CTRL:    rd_data = ctrl_reg;
      `ADDR_TAPS:    rd_data = {18'h00000, taps_reg};
      `ADDR_STATUS:  rd_data = {24'h000000, lock_reg, code_reg};
      `ADDR_LATCHED: rd_data = {25'h0000000, latch_reg};
      default:       rd_data = 32'h0000_0000;
    endcase
  end

  // Register writes and bus responses
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `CTRL_RESET_VAL;
      taps_reg <= 14'h0000;
      prdata   <= 32'h0000_0000;
      pready   <= 1'b0;
      pslverr  <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~addr_mapped(paddr);
      if (rd_en & ~penable)
        prdata <= rd_data;
      if (wr_en & pready & addr_mapped(paddr)) begin
        if (paddr == `ADDR_CTRL)
          ctrl_reg <= {25'h0000000, pwdata[6:0]};
        if (paddr == `ADDR_TAPS)
          taps_reg <= pwdata[13:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Phase detector: edges of ref and fb sampled on pclk
  assign ref_rise = ref_clk_in & ~ref_d_reg;
  assign fb_rise  = fb_clk_in & ~fb_d_reg;
  // Ref edge while fb still low means feedback lags: shorten the chain
  assign fb_late  = ref_rise & ~fb_clk_in;
  // Fb edge while ref still low means feedback leads: lengthen it
  assign fb_early = fb_rise & ~ref_clk_in;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_d_reg <= 1'b0;
      fb_d_reg  <= 1'b0;
    end else begin
      ref_d_reg <= ref_clk_in;
      fb_d_reg  <= fb_clk_in;
    end
  end

  // Next code: one step per detected edge, saturating
  always @* begin
    code_next = code_reg;
    if (code_hold) begin
      code_next = code_reg;
    end else if (fb_late && code_reg != 7'h00) begin
      code_next = code_reg - 7'h01;
    end else if (fb_early && code_reg != 7'h7f) begin
      code_next = code_reg + 7'h01;
    end
  end

  // Code register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code_reg <= `CODE_RESET;
    end else begin
      code_reg <= code_next;
    end
  end

  // Latch takes what the bus shows, not the pending code
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_reg    <= `CODE_RESET;
      latched_code <= `CODE_RESET;
    end else if (code_update_latch) begin
      latch_reg    <= delay_code_bus;
      latched_code <= delay_code_bus;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Lock detection with hysteresis to ride out single-sample jitter
  always @* begin
    match_next = match_reg;
    miss_next  = miss_reg;
    lock_next  = lock_reg;
    if (ref_rise && fb_rise) begin
      miss_next = 4'h0;
      if (match_reg != `LOCK_COUNT)
        match_next = match_reg + 4'h1;
      else
        lock_next = 1'b1;
    end else if (ref_rise) begin
      match_next = 4'h0;
      if (miss_reg != `UNLOCK_COUNT)
        miss_next = miss_reg + 4'h1;
      else
        lock_next = 1'b0;
    end
  end

  // Lock counters and flag
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_reg <= 4'h0;
      miss_reg  <= 4'h0;
      lock_reg  <= 1'b0;
    end else begin
      match_reg <= match_next;
      miss_reg  <= miss_next;
      lock_reg  <= lock_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Secondary divider runs off the reference edges
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg     <= 2'h0;
      sec_src_reg <= 1'b0;
    end else begin
      if (ref_rise)
        div_reg <= div_reg + 2'h1;
      case (div_sel)
        `DIV_BY2: sec_src_reg <= div_reg[0];
        `DIV_BY4: sec_src_reg <= div_reg[1];
        default:  sec_src_reg <= ref_clk_in;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs, all registered; code broadcast to both slave lines
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      delay_code_bus <= `CODE_RESET;
    end else begin
      delay_code_bus <= code_reg;
    end
  end

  // Tap selects, clamped so a slave never sees a missing tap
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      primary_tap   <= 7'h00;
      secondary_tap <= 7'h00;
    end else begin
      primary_tap   <= clamp_tap(taps_reg[6:0]);
      secondary_tap <= clamp_tap(taps_reg[13:7]);
    end
  end

  // Fine shift select for the secondary output
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      secondary_fine <= `FINE_NONE;
    end else begin
      secondary_fine <= ctrl_reg[`CTRL_FINE_LSB+1:`CTRL_FINE_LSB];
    end
  end

  // Primary clock follows the reference one cycle late
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      primary_clock_out <= 1'b0;
    end else begin
      primary_clock_out <= ref_clk_in;
    end
  end

  // Secondary clock from the divider mux
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      secondary_clock_out <= 1'b0;
    end else begin
      secondary_clock_out <= sec_src_reg;
    end
  end

  // Duty correction enables, one per output
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      primary_dcc_en   <= 1'b0;
      secondary_dcc_en <= 1'b0;
    end else begin
      primary_dcc_en   <= ctrl_reg[`CTRL_DCC_P_BIT];
      secondary_dcc_en <= ctrl_reg[`CTRL_DCC_S_BIT];
    end
  end

  // Loop mode select
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      injection_removal_mode <= 1'b0;
    end else begin
      injection_removal_mode <= ctrl_reg[`CTRL_MODE_BIT];
    end
  end

  // Lock output
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock <= 1'b0;
    end else begin
      lock <= lock_reg;
    end
  end

endmodule // dll_ctrl

// file: tb/dll_ctrl_chk.sv
// Port checker for the delay loop control block
`timescale 1ns/1ps
module dll_ctrl_chk (
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic [11:0] paddr,
  input logic        pready,
  input logic        pslverr,
  input logic        ref_clk_in,
  input logic        code_hold,
  input logic        code_update_latch,
  input logic [6:0]  delay_code_bus,
  input logic [6:0]  latched_code,
  input logic        primary_clock_out,
  input logic        lock
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [4:0] cyc_reg;
  // Cycles since reset; nine ref rises need at least two cycles each
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) cyc_reg <= 5'h0;
    else if (cyc_reg != 5'h1f) cyc_reg <= cyc_reg + 5'h1;
  //////////////////////////////////////////////////////////////////////
  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_err_map: assert property (pready |-> pslverr ==
    (paddr > 12'h00c || paddr[1:0] != 2'h0)) else $error("bad slverr");
  a_code_step: assert property ($changed(delay_code_bus) |->
    delay_code_bus == $past(delay_code_bus) + 7'h1 ||
    delay_code_bus == $past(delay_code_bus) - 7'h1)
    else $error("code jumped");
  a_hold_freeze: assert property (code_hold [*3] |=>
    $stable(delay_code_bus)) else $error("code moved in hold");
  a_latch_take: assert property (code_update_latch |=>
    latched_code == $past(delay_code_bus)) else $error("latch missed");
  a_latch_keep: assert property (!code_update_latch |=>
    $stable(latched_code)) else $error("latched code moved");
  a_lock_late: assert property ($rose(lock) |-> cyc_reg >= 5'h12)
    else $error("lock too early");
  a_primary_delay: assert property (primary_clock_out ==
    $past(ref_clk_in)) else $error("primary clock wrong");
endmodule // dll_ctrl_chk

bind dll_ctrl dll_ctrl_chk dll_ctrl_chk_inst (.pclk, .presetn, .psel,
  .penable, .paddr, .pready, .pslverr, .ref_clk_in, .code_hold,
  .code_update_latch, .delay_code_bus, .latched_code, .primary_clock_out,
  .lock);

// file: tb/slave_delay_line.sv
// Slave delay line model fed by the broadcast code
`timescale 1ns/1ps
module slave_delay_line (
  input  logic       pclk,
  input  logic       presetn,
  input  logic [6:0] code_in,
  output logic [6:0] code_out
);
  // Follows the master every cycle; no hold of its own
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) code_out <= 7'h40;
    else code_out <= code_in;
endmodule // slave_delay_line

// file: tb/delay_locked_loop_control_test.sv
// Self-checking bench for the delay loop control block
`timescale 1ns/1ps
module delay_locked_loop_control_test;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        ref_clk_in, fb_clk_in, code_hold, code_update_latch, lock;
  logic        primary_clock_out, secondary_clock_out;
  logic        primary_dcc_en, secondary_dcc_en, injection_removal_mode;
  logic [1:0]  secondary_fine;
  logic [6:0]  delay_code_bus, latched_code, primary_tap, secondary_tap;
  logic [6:0]  s0, s1;
  logic [7:0]  lf;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, v;
  int          mismatches, compares, mcode, sec_rises, n0;
  logic        sec_d;
  dll_ctrl dll_ctrl_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .ref_clk_in, .fb_clk_in, .code_hold,
    .code_update_latch, .delay_code_bus, .latched_code, .primary_tap,
    .secondary_tap, .secondary_fine, .primary_clock_out, .secondary_clock_out,
    .primary_dcc_en, .secondary_dcc_en, .injection_removal_mode, .lock);
  // Two slave lines hang on one code bus
  slave_delay_line slave_delay_line_inst (.pclk, .presetn,
    .code_in(delay_code_bus), .code_out(s0));
  slave_delay_line slave_delay_line_inst2 (.pclk, .presetn,
    .code_in(delay_code_bus), .code_out(s1));
  //////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 0;
    forever #4 pclk = ~pclk;
  end
  // Counts rises of the secondary clock for the divider check
  always @(posedge pclk or negedge presetn)
    if (!presetn) begin
      sec_d <= 0;
      sec_rises <= 0;
    end else begin
      sec_d <= secondary_clock_out;
      if (secondary_clock_out && !sec_d) sec_rises <= sec_rises + 1;
    end
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic finish_test;
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One APB transfer; waits on pready with a bound
  task automatic apb(input logic w, input logic [11:0] a, input int d);
    int n = 0;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      mismatches++;
      finish_test;
    end
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // Pulses on ref and feedback, then two quiet cycles; model tracks code
  task automatic edges(input logic r, f, input int n);
    repeat (n) begin
      ref_clk_in <= r;
      fb_clk_in <= f;
      @(posedge pclk);
      ref_clk_in <= 0;
      fb_clk_in <= 0;
      repeat (2) @(posedge pclk);
      if (!code_hold) mcode += (f && !r) - (r && !f);
    end
  endtask
  task automatic code_chk(input int lk);
    apb(0, 12'h008, 0);
    chk(rd, {lk[0], mcode[6:0]});
    chk({s0, s1}, {mcode[6:0], mcode[6:0]});
    chk(delay_code_bus, mcode[6:0]);
    chk(lock, lk[0]);
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    {psel, penable, pwrite, ref_clk_in, fb_clk_in} = 0;
    {code_hold, code_update_latch, paddr, pwdata, presetn} = 0;
    lf = 8'h50;
    mcode = 64;
    repeat (8) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    code_chk(0);
    for (int i = 0; i < 4; i++) begin
      lf = lfsr(lf);
      v = {25'h0, i[1:0], 2'(i % 3), lf[2:0]};
      apb(1, 12'h000, v);
      repeat (2) @(posedge pclk);
      chk({secondary_fine, secondary_dcc_en, primary_dcc_en,
           injection_removal_mode}, {v[6:5], v[2:0]});
      apb(0, 12'h000, 0);
      chk(rd, v);
    end
    lf = lfsr(lf);
    apb(1, 12'h004, {~lf[6:0], lf[6:0]});
    repeat (2) @(posedge pclk);
    chk({secondary_tap, primary_tap}, {~lf[6:0], lf[6:0]});
    apb(0, 12'h010, 0);
    chk({rd[30:0], err}, 1);
    edges(1, 0, 5);
    code_chk(0);
    code_hold <= 1;
    edges(1, 0, 3);
    code_hold <= 0;
    code_chk(0);
    edges(0, 1, 7);
    code_chk(0);
    code_update_latch <= 1;
    @(posedge pclk) code_update_latch <= 0;
    v = mcode;
    edges(0, 1, 2);
    apb(0, 12'h00c, 0);
    chk(rd, v);
    chk(latched_code, v);
    apb(1, 12'h000, 32'h0000_0010);
    repeat (3) @(posedge pclk);
    n0 = sec_rises;
    edges(1, 1, 12);
    code_chk(1);
    chk(sec_rises - n0, 3);
    edges(1, 0, 6);
    code_chk(0);
    finish_test;
  end
endmodule // delay_locked_loop_control_test
